// *** rtl/sbs_cfg.svh ***
// Constants for the serial port block: register addresses, field positions,
// reset values and cycle counts. Definitions only; included by bare name.
`ifndef SBS_CFG_SVH
`define SBS_CFG_SVH

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define SBS_ADDR_POWER     8'h87
`define SBS_ADDR_TIMER_MODE_SELECT      8'h89
`define SBS_ADDR_SERIAL_CONTROL      8'h98
`define SBS_ADDR_IRQ_STAT  8'hc0
`define SBS_ADDR_IRQ_MASK  8'hc1
`define SBS_ADDR_BAUDSRC   8'hc2
`define SBS_ADDR_T1RELOAD  8'hc3
`define SBS_ADDR_T2RELOAD_LO 8'hc4
`define SBS_ADDR_T2RELOAD_HI 8'hc5
`define SBS_ADDR_DATA      8'hc6

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define SBS_BIT_DOUBLER    7
`define SBS_T1_MODE_HI     5
`define SBS_T1_MODE_LO     4
`define SBS_T1_AUTORELOAD  2'b10
`define SBS_IRQ_TX         0
`define SBS_IRQ_RX         1
`define SBS_RST_BYTE       8'h00
`define SBS_TX_IDLE        11'h7ff

// ----------------------------------------------------------------------------
// Cycle counts
// ----------------------------------------------------------------------------
`define SBS_T1_PRESCALE    12
`define SBS_T2_PRESCALE    2
`define SBS_OVERSAMPLE     5'h10
`define SBS_M2_BIT_SLOW    5'h04
`define SBS_M2_BIT_FAST    5'h02
`define SBS_M0_BIT         5'h0c
`define SBS_TXBITS_M0      4'h8
`define SBS_TXBITS_M1      4'ha
`define SBS_TXBITS_M23     4'hb
`define SBS_RXBITS_M0      4'h8
`define SBS_RXBITS_M1      4'h9
`define SBS_RXBITS_M23     4'ha

`endif

// *** rtl/sbs_pkg.sv ***
// Types shared by the serial port block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package sbs_pkg;

  // --------------------------------------------------------------------------
  // Serial control register layout, high bit first
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic serialModeHighBit;
    logic serialModeLowBit;
    logic multiprocAddressFilter;
    logic rxEnable;
    logic txNinthBit;
    logic rxNinthBit;
    logic txDoneFlag;
    logic rxDoneFlag;
  } sbs_serial_control_t;

  // --------------------------------------------------------------------------
  // Register port request
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic       wr;
    logic       rd;
  } sbs_req_t;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} sbs_rx_state_t;

endpackage

`default_nettype wire

// *** rtl/sbs_timer.sv ***
// Auto-reload up counter with a prescaler; pulses overflow for one cycle.
// Assumes run and reload come from logic on the same clock.
`default_nettype none

module sbs_timer #(
  parameter int WIDTH    = 8,
  parameter int PRESCALE = 12
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             srst,
  // Control
  input  wire logic             run,
  input  wire logic [WIDTH-1:0] reload,
  // Event
  output var  logic             overflow
);

  logic [7:0]       preCnt_r;
  logic [7:0]       preCnt_nxt;
  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;
  logic             ovf_nxt;

  always_comb
  begin
    preCnt_nxt = preCnt_r;
    count_nxt  = count_r;
    ovf_nxt    = 1'b0;
    // While stopped the count follows the reload value, so the first period
    // after a start is already a full reload period.
    if (!run)
    begin
      preCnt_nxt = 8'h00;
      count_nxt  = reload;
    end
    else
    begin
      if (preCnt_r == 8'(PRESCALE - 1))
      begin
        preCnt_nxt = 8'h00;
        if (&count_r)
        begin
          count_nxt = reload;
          ovf_nxt   = 1'b1;
        end
        else
        begin
          count_nxt = count_r + 1'b1;
        end
      end
      else
      begin
        preCnt_nxt = preCnt_r + 8'h01;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      preCnt_r <= 8'h00;
      count_r  <= '0;
      overflow <= 1'b0;
    end
    else
    begin
      preCnt_r <= preCnt_nxt;
      count_r  <= count_nxt;
      overflow <= ovf_nxt;
    end
  end

endmodule

`default_nettype wire

// *** rtl/sbs_serial_port.sv ***
// Serial port with four modes, baud timers, register port and interrupt.
// Assumes a single-cycle register master on the same clock; rxdPin is async.
//
// Operation
// R1 - The two mode bits of serial control pick mode 0 to 3, high bit first.
// R2 - In modes 2 and 3 with the address filter set, a character whose ninth bit is zero is dropped.
// R3 - Reception only starts while the receive enable bit is one.
// R4 - In modes 2 and 3 the transmit ninth bit is sent as data bit 8.
// R5 - In modes 2 and 3 received data bit 8 is stored in the receive ninth bit.
// R6 - The transmit done flag is set when a character has been sent.
// R7 - The receive done flag is set when a character has been received.
// R8 - In modes 1 and 3 the rate is half the timer 1 overflow rate, or the full rate when doubled.
// R9 - In mode 2 the rate is a quarter of the clock, or a half when doubled.
// R10 - The baud doubler is bit 7 of the power control register at 87H.
// R11 - The timer mode register at 89H picks timer mode 0 to 3, high bit first; here only mode 2 (auto-reload) runs timer 1.
// R12 - Software loads the timer 1 reload byte from the documented formula.
// R13 - Software loads the timer 2 reload pair from the documented formula.
// R14 - Software keeps serial interrupts masked while it sets the port up.
// R15 - Both done flags stay set until software clears them.
// R16 - Modes 1 to 3 send a start bit, eight or nine data bits LSB first and a stop bit.
//
// Strobed register access was chosen for this implementation.
`include "sbs_cfg.svh"
`default_nettype none

module sbs_serial_port
  import sbs_pkg::*;
#(
  parameter int T1_PRESCALE = `SBS_T1_PRESCALE,
  parameter int T2_PRESCALE = `SBS_T2_PRESCALE
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       srst,
  // Register port
  input  wire sbs_req_t   regReq,
  output logic [7:0]      regRdData,
  // Serial pins
  input  wire logic       rxdPin,
  output logic            txdPin,
  output logic            shiftClkPin,
  // Interrupt
  output logic            irq
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  sbs_serial_control_t     serial_control_r, serial_control_nxt;
  sbs_rx_state_t rxState_r, rxState_nxt;
  logic [7:0]  power_r, power_nxt, timer_mode_select_r, timer_mode_select_nxt, t1Reload_r, t1Reload_nxt;
  logic [15:0] t2Reload_r, t2Reload_nxt;
  logic [7:0]  rxData_r, rxData_nxt, rdData_r, rdData_nxt;
  logic [1:0]  irqStat_r, irqStat_nxt, irqMask_r, irqMask_nxt;
  logic        useT2_r, useT2_nxt, halfPhase_r, halfPhase_nxt;
  logic        irq_r, irq_nxt, shiftClk_r, shiftClk_nxt;
  logic [10:0] txShift_r, txShift_nxt;
  logic [4:0]  txPhase_r, txPhase_nxt, rxPhase_r, rxPhase_nxt;
  logic [3:0]  txLeft_r, txLeft_nxt, rxLeft_r, rxLeft_nxt;
  logic        txBusy_r, txBusy_nxt;
  logic [9:0]  rxShift_r, rxShift_nxt, rxFrame;
  logic        rxSync1_r, rxSync2_r, rxPrev_r;
  logic [1:0]  serMode;
  logic        baud_doubler, t1Run, t1Ovf, t2Ovf, sampleTick, tick;
  logic [4:0]  bitLen, halfLen;
  logic        sconWr, txStart, txFinish, rxFinish, rxAccept, rxBit9;
  logic [7:0]  rxByte;

  // --------------------------------------------------------------------------
  // Mode decode and bit timing
  // --------------------------------------------------------------------------
  assign serMode = {serial_control_r.serialModeHighBit, serial_control_r.serialModeLowBit};  // [R1]
  assign baud_doubler    = power_r[`SBS_BIT_DOUBLER];  // [R10]
  assign t1Run   = (timer_mode_select_r[`SBS_T1_MODE_HI:`SBS_T1_MODE_LO] == `SBS_T1_AUTORELOAD);  // [R11]
  assign sconWr  = regReq.wr && (regReq.addr == `SBS_ADDR_SERIAL_CONTROL);

  sbs_timer #(.WIDTH(8), .PRESCALE(T1_PRESCALE)) timer1 (
    .clock    (clock),
    .srst     (srst),
    .run      (t1Run),
    .reload   (t1Reload_r),
    .overflow (t1Ovf)
  );

  sbs_timer #(.WIDTH(16), .PRESCALE(T2_PRESCALE)) timer2 (
    .clock    (clock),
    .srst     (srst),
    .run      (useT2_r),
    .reload   (t2Reload_r),
    .overflow (t2Ovf)
  );

  // Timer 1 overflows are halved unless doubled; each bit is then oversampled.
  assign sampleTick = useT2_r ? t2Ovf : (t1Ovf && (baud_doubler || halfPhase_r));  // [R8]
  assign tick       = serMode[0] ? sampleTick : 1'b1;

  always_comb
  begin
    if (serMode == 2'b00)
    begin
      bitLen = `SBS_M0_BIT;
    end
    else if (serMode == 2'b10)
    begin
      bitLen = baud_doubler ? `SBS_M2_BIT_FAST : `SBS_M2_BIT_SLOW;  // [R9]
    end
    else
    begin
      bitLen = `SBS_OVERSAMPLE;
    end
    halfLen = bitLen >> 1;
  end

  // --------------------------------------------------------------------------
  // Transmitter
  // --------------------------------------------------------------------------
  // A data write while busy is dropped; software waits for the done flag.
  assign txStart  = regReq.wr && (regReq.addr == `SBS_ADDR_DATA) && !txBusy_r;
  assign txFinish = txBusy_r && tick && (txPhase_r == bitLen - 5'h01) && (txLeft_r == 4'h1);

  always_comb
  begin
    txBusy_nxt  = txBusy_r;
    txShift_nxt = txShift_r;
    txPhase_nxt = txPhase_r;
    txLeft_nxt  = txLeft_r;
    if (txStart)
    begin
      txBusy_nxt  = 1'b1;
      txPhase_nxt = 5'h00;
      if (serMode == 2'b00)
      begin
        txShift_nxt = {3'b111, regReq.wrData};
        txLeft_nxt  = `SBS_TXBITS_M0;
      end
      else
      begin
        txShift_nxt = {1'b1, (serMode[1] ? serial_control_r.txNinthBit : 1'b1),  // [R4]
                       regReq.wrData, 1'b0};  // [R16]
        txLeft_nxt  = serMode[1] ? `SBS_TXBITS_M23 : `SBS_TXBITS_M1;
      end
    end
    else if (txBusy_r && tick)
    begin
      if (txPhase_r == bitLen - 5'h01)
      begin
        txPhase_nxt = 5'h00;
        txShift_nxt = {1'b1, txShift_r[10:1]};
        txLeft_nxt  = txLeft_r - 4'h1;
        txBusy_nxt  = (txLeft_r != 4'h1);
      end
      else
      begin
        txPhase_nxt = txPhase_r + 5'h01;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Receiver
  // --------------------------------------------------------------------------
  assign rxFrame  = {rxSync2_r, rxShift_r[9:1]};
  assign rxBit9   = rxFrame[8];
  assign rxByte   = (serMode == 2'b00) ? rxFrame[9:2] :
                    ((serMode == 2'b01) ? rxFrame[8:1] : rxFrame[7:0]);
  assign rxFinish = (rxState_r == RX_DATA) && tick && (rxPhase_r == bitLen - 5'h01)
                    && (rxLeft_r == 4'h1);
  assign rxAccept = rxFinish && !(serMode[1] && serial_control_r.multiprocAddressFilter
                    && !rxBit9);  // [R2]

  always_comb
  begin
    rxState_nxt = rxState_r;
    rxPhase_nxt = rxPhase_r;
    rxLeft_nxt  = rxLeft_r;
    rxShift_nxt = rxShift_r;
    case (rxState_r)
      RX_IDLE:
      begin
        if (serial_control_r.rxEnable)  // [R3]
        begin
          if (serMode == 2'b00)
          begin
            if (!serial_control_r.rxDoneFlag)
            begin
              rxState_nxt = RX_DATA;
              rxPhase_nxt = halfLen;
              rxLeft_nxt  = `SBS_RXBITS_M0;
            end
          end
          else if (rxPrev_r && !rxSync2_r)
          begin
            rxState_nxt = RX_START;
            rxPhase_nxt = 5'h00;
          end
        end
      end
      RX_START:
      begin
        if (tick)
        begin
          if (rxPhase_r == halfLen - 5'h01)
          begin
            rxPhase_nxt = 5'h00;
            rxState_nxt = rxSync2_r ? RX_IDLE : RX_DATA;
            rxLeft_nxt  = serMode[1] ? `SBS_RXBITS_M23 : `SBS_RXBITS_M1;  // [R16]
          end
          else
          begin
            rxPhase_nxt = rxPhase_r + 5'h01;
          end
        end
      end
      RX_DATA:
      begin
        if (tick)
        begin
          if (rxPhase_r == bitLen - 5'h01)
          begin
            rxPhase_nxt = 5'h00;
            rxShift_nxt = rxFrame;
            rxLeft_nxt  = rxLeft_r - 4'h1;
            if (rxLeft_r == 4'h1)
            begin
              rxState_nxt = RX_IDLE;
            end
          end
          else
          begin
            rxPhase_nxt = rxPhase_r + 5'h01;
          end
        end
      end
      default:
      begin
        rxState_nxt = RX_IDLE;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Registers, interrupt and pins
  // --------------------------------------------------------------------------
  // Hardware sets are applied after software writes, so a set always wins.
  always_comb
  begin
    serial_control_nxt      = serial_control_r;
    power_nxt     = power_r;
    timer_mode_select_nxt      = timer_mode_select_r;
    t1Reload_nxt  = t1Reload_r;
    t2Reload_nxt  = t2Reload_r;
    useT2_nxt     = useT2_r;
    irqStat_nxt   = irqStat_r;
    irqMask_nxt   = irqMask_r;
    rxData_nxt    = rxData_r;
    halfPhase_nxt = halfPhase_r;
    rdData_nxt    = `SBS_RST_BYTE;
    if (t1Ovf)
    begin
      halfPhase_nxt = !halfPhase_r;
    end
    if (regReq.wr)
    begin
      if (sconWr)
      begin
        serial_control_nxt = sbs_serial_control_t'(regReq.wrData);
      end
      else if (regReq.addr == `SBS_ADDR_POWER)
      begin
        power_nxt = regReq.wrData;
      end
      else if (regReq.addr == `SBS_ADDR_TIMER_MODE_SELECT)
      begin
        timer_mode_select_nxt = regReq.wrData;
      end
      else if (regReq.addr == `SBS_ADDR_T1RELOAD)
      begin
        t1Reload_nxt = regReq.wrData;
      end
      else if (regReq.addr == `SBS_ADDR_T2RELOAD_LO)
      begin
        t2Reload_nxt[7:0] = regReq.wrData;
      end
      else if (regReq.addr == `SBS_ADDR_T2RELOAD_HI)
      begin
        t2Reload_nxt[15:8] = regReq.wrData;
      end
      else if (regReq.addr == `SBS_ADDR_BAUDSRC)
      begin
        useT2_nxt = regReq.wrData[0];
      end
      else if (regReq.addr == `SBS_ADDR_IRQ_STAT)
      begin
        irqStat_nxt = irqStat_r & ~regReq.wrData[1:0];
      end
      else if (regReq.addr == `SBS_ADDR_IRQ_MASK)
      begin
        irqMask_nxt = regReq.wrData[1:0];
      end
    end
    if (txFinish)
    begin
      serial_control_nxt.txDoneFlag           = 1'b1;  // [R6] [R15]
      irqStat_nxt[`SBS_IRQ_TX]      = 1'b1;
    end
    if (rxAccept)
    begin
      serial_control_nxt.rxDoneFlag           = 1'b1;  // [R7] [R15]
      irqStat_nxt[`SBS_IRQ_RX]      = 1'b1;
      rxData_nxt                    = rxByte;
      if (serMode[1])
      begin
        serial_control_nxt.rxNinthBit = rxBit9;  // [R5]
      end
    end
    if (regReq.rd)
    begin
      if (regReq.addr == `SBS_ADDR_SERIAL_CONTROL)
      begin
        rdData_nxt = serial_control_r;
      end
      else if (regReq.addr == `SBS_ADDR_POWER)
      begin
        rdData_nxt = power_r;
      end
      else if (regReq.addr == `SBS_ADDR_TIMER_MODE_SELECT)
      begin
        rdData_nxt = timer_mode_select_r;
      end
      else if (regReq.addr == `SBS_ADDR_T1RELOAD)
      begin
        rdData_nxt = t1Reload_r;
      end
      else if (regReq.addr == `SBS_ADDR_T2RELOAD_LO)
      begin
        rdData_nxt = t2Reload_r[7:0];
      end
      else if (regReq.addr == `SBS_ADDR_T2RELOAD_HI)
      begin
        rdData_nxt = t2Reload_r[15:8];
      end
      else if (regReq.addr == `SBS_ADDR_BAUDSRC)
      begin
        rdData_nxt = {7'h00, useT2_r};
      end
      else if (regReq.addr == `SBS_ADDR_IRQ_STAT)
      begin
        rdData_nxt = {6'h00, irqStat_r};
      end
      else if (regReq.addr == `SBS_ADDR_IRQ_MASK)
      begin
        rdData_nxt = {6'h00, irqMask_r};
      end
      else if (regReq.addr == `SBS_ADDR_DATA)
      begin
        rdData_nxt = rxData_r;
      end
    end
    irq_nxt      = |(irqStat_r & irqMask_r);
    shiftClk_nxt = !((serMode == 2'b00) && ((txBusy_r && (txPhase_r < halfLen)) ||
                   ((rxState_r == RX_DATA) && (rxPhase_r < halfLen))));
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      serial_control_r <= sbs_serial_control_t'(`SBS_RST_BYTE);
      power_r <= `SBS_RST_BYTE;
      timer_mode_select_r <= `SBS_RST_BYTE;
      t1Reload_r <= `SBS_RST_BYTE;
      t2Reload_r <= 16'h0000;
      useT2_r <= 1'b0;
      irqStat_r <= 2'b00;
      irqMask_r <= 2'b00;
      rxData_r <= `SBS_RST_BYTE;
      rdData_r <= `SBS_RST_BYTE;
      halfPhase_r <= 1'b0;
      irq_r <= 1'b0;
      shiftClk_r <= 1'b1;
      txBusy_r <= 1'b0;
      txShift_r <= `SBS_TX_IDLE;
      txPhase_r <= 5'h00;
      txLeft_r <= 4'h0;
      rxState_r <= RX_IDLE;
      rxPhase_r <= 5'h00;
      rxLeft_r <= 4'h0;
      rxShift_r <= 10'h000;
      rxSync1_r <= 1'b1;
      rxSync2_r <= 1'b1;
      rxPrev_r <= 1'b1;
    end
    else
    begin
      serial_control_r <= serial_control_nxt;
      power_r <= power_nxt;
      timer_mode_select_r <= timer_mode_select_nxt;
      t1Reload_r <= t1Reload_nxt;
      t2Reload_r <= t2Reload_nxt;
      useT2_r <= useT2_nxt;
      irqStat_r <= irqStat_nxt;
      irqMask_r <= irqMask_nxt;
      rxData_r <= rxData_nxt;
      rdData_r <= rdData_nxt;
      halfPhase_r <= halfPhase_nxt;
      irq_r <= irq_nxt;
      shiftClk_r <= shiftClk_nxt;
      txBusy_r <= txBusy_nxt;
      txShift_r <= txShift_nxt;
      txPhase_r <= txPhase_nxt;
      txLeft_r <= txLeft_nxt;
      rxState_r <= rxState_nxt;
      rxPhase_r <= rxPhase_nxt;
      rxLeft_r <= rxLeft_nxt;
      rxShift_r <= rxShift_nxt;
      rxSync1_r <= rxdPin;
      rxSync2_r <= rxSync1_r;
      rxPrev_r <= rxSync2_r;
    end
  end

  assign regRdData   = rdData_r;
  assign txdPin      = txShift_r[0];
  assign shiftClkPin = shiftClk_r;
  assign irq         = irq_r;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  mode_write_a: assert property (sconWr |=> serMode == $past(regReq.wrData[7:6])) // [R1]
    else $error("serial mode does not follow control write");
  filter_drop_a: assert property ((rxFinish && serMode[1] && serial_control_r.multiprocAddressFilter // [R2]
    && !rxBit9 && !sconWr) |=> serial_control_r.rxDoneFlag == $past(serial_control_r.rxDoneFlag))
    else $error("filtered character raised receive done");
  rx_gate_a: assert property ((rxState_r == RX_IDLE && !serial_control_r.rxEnable) // [R3]
    |=> rxState_r == RX_IDLE)
    else $error("receiver started while disabled");
  tx_ninth_a: assert property ((txStart && serMode[1]) |=> // [R4]
    (txShift_r[9] == $past(serial_control_r.txNinthBit)) && (txLeft_r == 4'hb))
    else $error("transmit ninth bit not framed");
  rx_ninth_a: assert property ((rxAccept && serMode[1] && !sconWr) |=> // [R5]
    serial_control_r.rxNinthBit == $past(rxBit9))
    else $error("receive ninth bit not stored");
  tx_done_a: assert property (txFinish |=> serial_control_r.txDoneFlag && irqStat_r[0]) // [R6]
    else $error("transmit done not set");
  rx_done_a: assert property (rxAccept |=> serial_control_r.rxDoneFlag && irqStat_r[1]) // [R7]
    else $error("receive done not set");
  tick_halving_a: assert property ((serMode[0] && !useT2_r && t1Ovf) |-> // [R8]
    (sampleTick == (baud_doubler || halfPhase_r)))
    else $error("timer 1 overflow not halved");
  mode2_rate_a: assert property ((txStart && serMode == 2'b10 && !baud_doubler) |-> // [R9]
    ##4 (txLeft_r == 4'hb) ##1 (txLeft_r == 4'ha))
    else $error("mode 2 bit is not four clocks");
  doubler_bit_a: assert property ((regReq.wr && regReq.addr == `SBS_ADDR_POWER) |=> // [R10]
    baud_doubler == $past(regReq.wrData[7]))
    else $error("baud doubler not at bit 7");
  timer_mode_a: assert property (t1Ovf |-> $past(t1Run)) // [R11]
    else $error("timer 1 counted outside its mode");
  done_hold_a: assert property ((serial_control_r.txDoneFlag && !sconWr) |=> serial_control_r.txDoneFlag) // [R15]
    else $error("transmit done cleared by hardware");
  frame_shape_a: assert property ((txStart && serMode == 2'b01) |=> // [R16]
    (txShift_r[0] == 1'b0) && (txShift_r[9] == 1'b1) && (txLeft_r == 4'ha))
    else $error("mode 1 frame badly formed");

endmodule

`default_nettype wire

// *** tb/sbs_peer.sv ***
// Serial peer on the far side of the port: sends and captures framed characters.
// Assumes the testbench sets bitLen to the clocks per bit of the mode in use.
`default_nettype none

module sbs_peer (
  // Clock
  input  wire logic clock,
  // Serial line
  input  wire logic txdPin,
  output var  logic rxdPin
);
  int bitLen = 4;

  initial rxdPin = 1'b1;

  // ---------------------------------------------------------------------------
  // Frames: start, data LSB first, ninth bit, stop
  // ---------------------------------------------------------------------------
  task automatic send(input logic [7:0] d, input logic n);
    logic [10:0] f;
    f = {1'b1, n, d, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      @(posedge clock);
      rxdPin <= f[i];
      repeat (bitLen - 1) @(posedge clock);
    end
  endtask

  // Sampling mid bit, so a wrong bit rate shows up as wrong data.
  task automatic capture(output logic [9:0] f, output logic ok);
    ok = 1'b0;
    f = '0;
    for (int w = 0; w < 100 && !ok; w++)
    begin
      @(posedge clock);
      ok = (txdPin === 1'b0);
    end
    repeat ((bitLen - 1) / 2) @(posedge clock);
    for (int i = 0; i < 10; i++)
    begin
      repeat (bitLen) @(posedge clock);
      f[i] = txdPin;
    end
  endtask
endmodule

`default_nettype wire

// *** tb/sbs_serial_port_tb.sv ***
// Testbench for the serial port: register master, serial peer, expected values.
// Assumes the package, the design and the peer are compiled first.
`default_nettype none

module sbs_serial_port_tb
  import sbs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic       clock;
  logic       srst;
  sbs_req_t   req;
  logic [7:0] rdData;
  logic       txd;
  logic       rxd;
  logic       sclk;
  logic       irq;
  int         fails = 0;
  int         tests_run = 0;
  logic [7:0] seed = 8'h15;

  sbs_serial_port sbs_serial_port_inst (.clock(clock), .srst(srst), .regReq(req),
    .regRdData(rdData), .rxdPin(rxd), .txdPin(txd), .shiftClkPin(sclk), .irq(irq));
  sbs_peer sbs_peer_inst (.clock(clock), .txdPin(txd), .rxdPin(rxd));

  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic conclude();
    $display("tests %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= '{addr: a, wrData: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    req.wr <= 1'b0;
  endtask

  task automatic rdChk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    req <= '{addr: a, wrData: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    req.rd <= 1'b0;
    #1 check(what, exp, rdData);
  endtask

  // Receive one character under control value sc and expect control value ex.
  task automatic rxCase(input logic [7:0] sc, input logic n, input logic [7:0] ex);
    wr(8'h98, sc);
    seed = lfsr(seed);
    sbs_peer_inst.send(seed, n);
    repeat (sbs_peer_inst.bitLen + 3) @(posedge clock);
    rdChk("serial control", 8'h98, ex);
    if (ex[0])
      rdChk("rx data", 8'hc6, seed);
  endtask

  // Send one random byte under control value sc; b8 is the bit expected after the data.
  task automatic txCase(input logic [7:0] sc, input logic b8);
    logic [9:0] f;
    logic       ok;
    wr(8'h98, sc);
    seed = lfsr(seed);
    fork
      sbs_peer_inst.capture(f, ok);
      wr(8'hc6, seed);
    join
    check("tx start", 8'h01, {7'h00, ok});
    if (!ok)
      conclude();
    check("tx data", seed, f[7:0]);
    check("tx bit 8", {7'h00, b8}, {7'h00, f[8]});
    check("tx stop", 8'h01, {7'h00, f[9]});
    repeat (sbs_peer_inst.bitLen + 2) @(posedge clock);
    rdChk("tx done", 8'h98, sc | 8'h02);
  endtask

  initial
  begin
    repeat (20000) @(posedge clock);
    fails++;
    conclude();
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial
  begin
    logic       n;
    req = '0;
    srst = 1'b1;
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    rdChk("power", 8'h87, 8'h00);
    rdChk("timer mode", 8'h89, 8'h00);
    rdChk("serial control", 8'h98, 8'h00);
    rdChk("unmapped", 8'h50, 8'h00);
    check("shift clock idle", 8'h01, {7'h00, sclk});
    $display("test reset done");
    wr(8'hc3, 8'hff);
    wr(8'h89, 8'h20);
    rdChk("timer mode", 8'h89, 8'h20);
    for (int m = 0; m < 4; m++)
    begin
      wr(8'h98, {m[1:0], 6'h00});
      rdChk("mode bits", 8'h98, {m[1:0], 6'h00});
    end
    $display("test registers done");
    for (int dbl = 0; dbl < 2; dbl++)
    begin
      wr(8'hc1, 8'h00);
      wr(8'h87, {dbl[0], 7'h00});
      rdChk("power", 8'h87, {dbl[0], 7'h00});
      // Reload ff overflows every 12 clocks, so a mode 1 bit is 384 clocks, halved when doubled.
      sbs_peer_inst.bitLen = 384 >> dbl;
      txCase(8'h40, 1'b1);
      wr(8'hc0, 8'h03);
      sbs_peer_inst.bitLen = 4 >> dbl;
      seed = lfsr(seed);
      n = seed[0];
      txCase({4'h8, n, 3'h0}, n);
      wr(8'hc1, 8'h03);
      repeat (2) @(posedge clock);
      check("irq raised", 8'h01, {7'h00, irq});
      wr(8'hc1, 8'h00);
      repeat (2) @(posedge clock);
      check("irq masked", 8'h00, {7'h00, irq});
      wr(8'hc1, 8'h03);
      wr(8'hc0, 8'h03);
      repeat (2) @(posedge clock);
      check("irq cleared", 8'h00, {7'h00, irq});
      rxCase(8'h90, 1'b1, 8'h95);
      rxCase(8'h90, 1'b0, 8'h91);
      rxCase(8'hb0, 1'b0, 8'hb0);
      rxCase(8'hb0, 1'b1, 8'hb5);
      rdChk("rx done held", 8'h98, 8'hb5);
      rxCase(8'h80, 1'b1, 8'h80);
      $display("test serial pass %0d done", dbl);
    end
    wr(8'hc4, 8'hff);
    wr(8'hc5, 8'hff);
    wr(8'hc2, 8'h01);
    sbs_peer_inst.bitLen = 32;
    txCase(8'hc0, 1'b0);
    $display("test timer 2 done");
    conclude();
  end
endmodule

`default_nettype wire
